// ### core/amx_decode.sv
// Combinational decode from the select bytes to the analog switch enables.
module amx_decode
   import amx_pkg::*;
(
   input  wire logic [7:0]   i_input_sel,
   input  wire logic [7:0]   i_status,
   output amx_chan_sw_t      o_chan,
   output amx_cmp_sw_t       o_cmp
);
   wire logic [3:0]   pins_on;
   wire logic         any_pin;
   wire amx_cmp_src_t src;

   // Pins need no interlock: each bit maps straight to its switch.
   assign pins_on = i_input_sel[AMX_BIT_PIN4:AMX_BIT_PIN1];
   assign any_pin = |pins_on;
   assign src     = amx_cmp_src_t'({i_input_sel[AMX_BIT_DIRECT], i_input_sel[AMX_BIT_DIVIDED]});

   assign o_chan.pin_switch_en  = pins_on;
   assign o_chan.supply_rail_en = ~any_pin & i_input_sel[AMX_BIT_RAIL];
   assign o_chan.ground_rail_en = ~any_pin & ~i_input_sel[AMX_BIT_RAIL];

   // Both path bits select the diode, never divider and direct together.
   assign o_cmp.direct_en      = (src == AMX_CMP_DIRECT);
   assign o_cmp.divided_en     = (src == AMX_CMP_DIVIDED);
   assign o_cmp.comp_switch_en = (src == AMX_CMP_DIVIDED);
   assign o_cmp.temp_diode_en  = (src == AMX_CMP_TEMP);
   assign o_cmp.cap_offset_en  = i_status[AMX_BIT_CAP_OFFSET];
endmodule : amx_decode

// ### core/amx_pkg.sv
// Package for the analog input-select control block: map, fields, carriers.
package amx_pkg;
   localparam logic [31:0] AMX_ADDR_INPUT_SEL  = 32'h0000_0003;
   localparam logic [31:0] AMX_ADDR_STATUS     = 32'h0000_0004;
   localparam logic [31:0] AMX_BYTE_ADDR_SCALE = 32'h0000_0004;
   localparam int          AMX_BIT_PIN1        = 0;
   localparam int          AMX_BIT_PIN2        = 1;
   localparam int          AMX_BIT_PIN3        = 2;
   localparam int          AMX_BIT_PIN4        = 3;
   localparam int          AMX_BIT_RAIL        = 4;
   localparam int          AMX_BIT_DIVIDED     = 5;
   localparam int          AMX_BIT_DIRECT      = 6;
   localparam int          AMX_BIT_CAP_OFFSET  = 0;
   localparam logic [7:0]  AMX_INPUT_SEL_RESET = 8'h00;
   localparam logic [7:0]  AMX_STATUS_RESET    = 8'h00;
   localparam logic [7:0]  AMX_INPUT_SEL_MASK  = 8'h7f;
   localparam logic [7:0]  AMX_STATUS_MASK     = 8'h01;
   localparam logic [1:0]  AMX_HTRANS_NONSEQ   = 2'h2;
   localparam logic [2:0]  AMX_HSIZE_WORD      = 3'h2;

   typedef enum logic [1:0]
   {
      AMX_CMP_HOLD    = 2'h0,
      AMX_CMP_DIVIDED = 2'h1,
      AMX_CMP_DIRECT  = 2'h2,
      AMX_CMP_TEMP    = 2'h3
   } amx_cmp_src_t;

   typedef struct packed
   {
      logic [3:0] pin_switch_en;
      logic       supply_rail_en;
      logic       ground_rail_en;
   } amx_chan_sw_t;

   typedef struct packed
   {
      logic direct_en;
      logic divided_en;
      logic comp_switch_en;
      logic temp_diode_en;
      logic cap_offset_en;
   } amx_cmp_sw_t;
endpackage : amx_pkg

// ### core/amx_top.sv
// AHB-Lite register slave driving the analog channel and comparator switches.
// Operation
// - Select register at address 0x0003 holds controls.
// - Each pin bit closes its own switch.
// - No pins set: rail bit picks supply/ground.
// - Any pin set opens both rail switches.
// - Register changes go straight to switches.
// - Pin switches ignore digital port configuration.
// - Comparator bus ends on comparator 2 negative.
// - Path bits: hold, divided, direct, temperature.
// - Both path bits select temperature diode.
// - Status offset bit steers sample capacitor reference.
// - Divided path also enables compensation switch.
//
// The implementer's own choice: register access over AHB-Lite.
module amx_top
   import amx_pkg::*;
(
   input  wire logic         i_core_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_hsel,
   input  wire logic [31:0]  i_haddr,
   input  wire logic [1:0]   i_htrans,
   input  wire logic         i_hwrite,
   input  wire logic [2:0]   i_hsize,
   input  wire logic [31:0]  i_hwdata,
   input  wire logic         i_hready,
   output logic      [31:0]  o_hrdata,
   output logic              o_hreadyout,
   output logic              o_hresp,
   output amx_chan_sw_t      o_chan,
   output amx_cmp_sw_t       o_cmp
);
   logic         [7:0]  input_sel;
   logic         [7:0]  status;
   logic                wr_pend;
   logic                wr_is_sel;
   logic                wr_is_stat;
   wire  logic          take;
   wire  logic          hit_sel;
   wire  logic          hit_stat;
   wire  logic   [7:0]  next_input_sel;
   wire  logic   [7:0]  next_status;
   wire  logic   [31:0] next_rdata;
   wire  amx_chan_sw_t  next_chan;
   wire  amx_cmp_sw_t   next_cmp;

   // Byte address is four times the printed index, one aligned word each.
   assign take     = i_hsel & i_hready & (i_htrans == AMX_HTRANS_NONSEQ);
   assign hit_sel  = (i_haddr == AMX_ADDR_INPUT_SEL * AMX_BYTE_ADDR_SCALE);
   assign hit_stat = (i_haddr == AMX_ADDR_STATUS * AMX_BYTE_ADDR_SCALE);

   assign next_input_sel = (wr_pend & wr_is_sel) ? (i_hwdata[7:0] & AMX_INPUT_SEL_MASK)
                                                 : input_sel;
   assign next_status    = (wr_pend & wr_is_stat) ? (i_hwdata[7:0] & AMX_STATUS_MASK)
                                                  : status;
   assign next_rdata     = hit_sel  ? {24'h00_0000, input_sel} :
                           hit_stat ? {24'h00_0000, status}    : 32'h0000_0000;

   // The decode sees next values so switches follow at the write's data-phase edge.
   amx_decode u_decode
   (
      .i_input_sel (next_input_sel),
      .i_status    (next_status),
      .o_chan      (next_chan),
      .o_cmp       (next_cmp)
   );

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         wr_pend    <= 1'b0;
         wr_is_sel  <= 1'b0;
         wr_is_stat <= 1'b0;
      end
      else
      begin
         wr_pend    <= take & i_hwrite;
         wr_is_sel  <= hit_sel;
         wr_is_stat <= hit_stat;
      end
   end

   // No break-before-make: one write may move several switches at once.
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         input_sel   <= AMX_INPUT_SEL_RESET;
         status      <= AMX_STATUS_RESET;
         o_chan      <= '0;
         o_cmp       <= '0;
         o_hrdata    <= 32'h0000_0000;
         o_hreadyout <= 1'b0;
         o_hresp     <= 1'b0;
      end
      else
      begin
         input_sel   <= next_input_sel;
         status      <= next_status;
         o_chan      <= next_chan;
         o_cmp       <= next_cmp;
         o_hrdata    <= (take & ~i_hwrite) ? next_rdata : 32'h0000_0000;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end
   end
endmodule : amx_top

// ### tb/amx_assertions.sv
// Concurrent checks on the ports of the analog select block.
module amx_checker
   import amx_pkg::*;
(
   input wire logic         i_core_clk,
   input wire logic         i_rst_n,
   input wire logic         i_hsel,
   input wire logic [31:0]  i_haddr,
   input wire logic [1:0]   i_htrans,
   input wire logic         i_hwrite,
   input wire logic [31:0]  i_hwdata,
   input wire logic         i_hready,
   input wire logic [31:0]  o_hrdata,
   input wire logic         o_hreadyout,
   input wire logic         o_hresp,
   input wire amx_chan_sw_t o_chan,
   input wire amx_cmp_sw_t  o_cmp
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   wire hit = i_hsel && i_hready && i_htrans == AMX_HTRANS_NONSEQ && i_haddr == 32'h0000_000c;
   wire hit_st = i_hsel && i_hready && i_htrans == AMX_HTRANS_NONSEQ && i_haddr == 32'h0000_0010;
   sequence wr_s;
      hit && i_hwrite ##1 1'b1;
   endsequence
   sequence st_wr_s;
      hit_st && i_hwrite ##1 1'b1;
   endsequence
   a_rail_open: assert property (|o_chan.pin_switch_en |->
      !o_chan.supply_rail_en && !o_chan.ground_rail_en) else $error("rail closed");
   a_rail_pick: assert property ($past(i_rst_n) && !(|o_chan.pin_switch_en) |->
      o_chan.supply_rail_en != o_chan.ground_rail_en) else $error("rail choice");
   a_path_one: assert property ($onehot0({o_cmp.direct_en, o_cmp.divided_en,
      o_cmp.temp_diode_en})) else $error("path overlap");
   a_comp_track: assert property (o_cmp.comp_switch_en == o_cmp.divided_en)
      else $error("comp switch");
   a_pin_apply: assert property (wr_s |=> o_chan.pin_switch_en == $past(i_hwdata[3:0]))
      else $error("pin apply");
   a_temp_pick: assert property (wr_s |=> o_cmp.temp_diode_en == &$past(i_hwdata[6:5]))
      else $error("temp pick");
   a_cap_apply: assert property (st_wr_s |=> o_cmp.cap_offset_en == $past(i_hwdata[0]))
      else $error("cap offset");
   a_okay_ready: assert property ($past(i_rst_n) |-> o_hreadyout && !o_hresp)
      else $error("bus answer");
   a_read_back: assert property (hit && !i_hwrite && !$past(hit && i_hwrite) |=>
      o_hrdata[3:0] == o_chan.pin_switch_en) else $error("read back");
endmodule : amx_checker

bind amx_top amx_checker chk (.i_core_clk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans,
   .i_hwrite, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .o_chan, .o_cmp);

// ### tb/tb.sv
// Randomised self-checking bench for the analog select block.
module tb import amx_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_total++; \
   $display("Error %s exp %h got %h", n, e, a); end end
   logic         clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
   logic [1:0]   htrans = 0;
   logic [31:0]  haddr = 0, hwdata = 0, hrdata, rd, lfsr = 32'h9899_0351;
   logic [7:0]   sel;
   amx_chan_sw_t chan;
   amx_cmp_sw_t  cmp;
   int           err_total = 0, num_checks = 0, cyc = 0;
   logic [7:0]   corner [7] = '{8'h00, 8'h10, 8'h6f, 8'h70, 8'h20, 8'h40, 8'h30};
   always #10 clk = ~clk;
   amx_top uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(AMX_HSIZE_WORD), .i_hwdata(hwdata),
      .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
      .o_chan(chan), .o_cmp(cmp));
   function automatic logic [10:0] exp_sw(input logic [7:0] s, input logic c);
      exp_sw = {s[3:0], ~|s[3:0] & s[4], ~|s[3:0] & ~s[4], s[6] & ~s[5], s[5] & ~s[6],
                s[5] & ~s[6], s[6] & s[5], c};
   endfunction : exp_sw
   function automatic logic [31:0] lfsr_step(input logic [31:0] v);
      lfsr_step = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_step
   // Single word transfers; the bus never pipelines, so one task covers both phases.
   task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= AMX_HTRANS_NONSEQ;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : bus
   task automatic complete_run();
      if (err_total == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_total++;
         complete_run();
      end
   end
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 60; i++)
      begin
         lfsr = lfsr_step(lfsr);
         sel = (i < 7) ? corner[i] : lfsr[7:0];
         bus(1'b1, AMX_ADDR_INPUT_SEL * AMX_BYTE_ADDR_SCALE, {lfsr[31:8], sel}, rd);
         bus(1'b1, AMX_ADDR_STATUS * AMX_BYTE_ADDR_SCALE, lfsr, rd);
         bus(1'b0, AMX_ADDR_STATUS * AMX_BYTE_ADDR_SCALE, 32'h0, rd);
         `CHK("status", {31'h0, lfsr[0]}, rd)
         bus(1'b0, AMX_ADDR_INPUT_SEL * AMX_BYTE_ADDR_SCALE, 32'h0, rd);
         `CHK("readback", {24'h0, sel & AMX_INPUT_SEL_MASK}, rd)
         bus(1'b1, 32'h0000_0020, 32'hffff_ffff, rd);
         bus(1'b0, 32'h0000_0020, 32'h0, rd);
         `CHK("unmapped", 32'h0, rd)
         `CHK("switches", exp_sw(sel, lfsr[0]), {chan, cmp})
      end
      // Software moves one pin bit per write, closing pins 1 to 4 in turn and then opening them, so up to four channels short together.
      sel = 8'h00;
      bus(1'b1, AMX_ADDR_INPUT_SEL * AMX_BYTE_ADDR_SCALE, 32'h0, rd);
      for (int j = 0; j < 8; j++)
      begin
         sel = sel ^ (8'h01 << (j % 4));
         bus(1'b1, AMX_ADDR_INPUT_SEL * AMX_BYTE_ADDR_SCALE, {24'h0, sel}, rd);
         bus(1'b0, AMX_ADDR_INPUT_SEL * AMX_BYTE_ADDR_SCALE, 32'h0, rd);
         `CHK("walk readback", {24'h0, sel}, rd)
         `CHK("walk switches", exp_sw(sel, lfsr[0]), {chan, cmp})
      end
      complete_run();
   end
endmodule : tb
